// ==== lsm_pkg.sv ====
package lsm_pkg;

	// Timing: bit time and clock rate, strobe and stretch lengths converted to clock cycles
	localparam int CLK_HZ          = 25_000_000;
	localparam int BIT_TIME_NS     = 100;
	localparam int STROBE_BITS     = 64;
	localparam int STROBE_NS       = STROBE_BITS * BIT_TIME_NS;
	localparam int STROBE_CYC      = (STROBE_NS * (CLK_HZ / 1_000_000)) / 1000;
	localparam int STRETCH_MS      = 4;
	localparam int STRETCH_CYC     = STRETCH_MS * (CLK_HZ / 1000);

	// Port, attribute and slot counts
	localparam int N_SE_PORTS      = 12;
	localparam int N_PORTS         = 14;
	localparam int N_ATTR          = 5;
	localparam int N_SLOTS         = 10;

	// Lamp bus bit positions in the high bank, bank bases and attachment port indices
	localparam int HI_STD_BIT      = 4;
	localparam int HI_REV_BIT      = 5;
	localparam int HI_EXP_BIT      = 6;
	localparam int HI_SHR_LO_BIT   = 6;
	localparam int HI_SHR_HI_BIT   = 7;
	localparam int LO_BANK_BASE    = 0;
	localparam int HI_BANK_BASE    = 8;
	localparam int STD_PORT_IDX    = 12;
	localparam int REV_PORT_IDX    = 13;

	typedef enum logic [2:0]
	{
		LSM_ATTR_ACT  = 3'h0,
		LSM_ATTR_COL  = 3'h1,
		LSM_ATTR_PARTITION_STROBE = 3'h2,
		LSM_ATTR_LINK = 3'h3,
		LSM_ATTR_POL  = 3'h4
	} lsm_attr_t;

	// Per-port raw status from the repeater core and serial status logic
	typedef struct packed
	{
		logic [13:0] activity;
		logic [13:0] collision;
		logic [13:0] connected;
		logic [13:0] link_good;
		logic [13:0] pol_ok;
	} lsm_port_stat_t;

	// Status of the shared transceiver's ports 2 and 3 plus expansion bus
	typedef struct packed
	{
		logic       owner;
		logic [1:0] link_good;
		logic [1:0] pol_ok;
		logic       exp_activity;
		logic       exp_collision;
	} lsm_aux_stat_t;

	// Attribute strobes, one-hot
	typedef struct packed
	{
		logic activity_strobe;
		logic collision_strobe;
		logic partition_strobe;
		logic link_strobe;
		logic polarity_strobe;
	} lsm_strobes_t;

endpackage

// ==== lsm_stretch.sv ====
`timescale 1ns/100ps
// Pulse stretcher: output stays high HOLD_CYC cycles after the last event
module lsm_stretch #(
	parameter int HOLD_CYC = lsm_pkg::STRETCH_CYC
) (
	input  wire logic sys_clk,
	input  wire logic reset_n,
	input  wire logic event_in,
	output logic      held_q
);
	localparam int CW = $clog2(HOLD_CYC + 1);
	localparam logic [CW-1:0] LOAD = CW'(HOLD_CYC - 1);

	logic [CW-1:0] count_q;

	// Every event reloads the timer; expiry drops the held level
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			count_q <= '0;
			held_q  <= 1'b0;
		end
		else if (event_in)
		begin
			count_q <= LOAD;
			held_q  <= 1'b1;
		end
		else if (count_q != '0)
		begin
			count_q <= count_q - 1'b1;
		end
		else
		begin
			held_q <= 1'b0;
		end
	end

	chk_hold_after_event: assert property (@(posedge sys_clk) disable iff (!reset_n)
		event_in |=> held_q [*8])
		else $error("stretched output dropped too early");

endmodule

// ==== lsm_monitor.sv ====
`timescale 1ns/100ps
// Overview of operation
// - Five attributes, 8-bit lamp bus, fourteen ports
// - Low bank: single-ended ports 7..0
// - High bank: ports 11..8, standard, reversible
// - High bits 7..6 show shared transceiver
// - One attribute strobe high at once
// - Each strobe lasts 64 bit times
// - High means active, connected, good, correct
// - Expansion bus on bit 6, activity/collision
// - Link, polarity from serial status line
// - Shared link status only when owner
// - Link/partition strobes: shared ports 2, 3
// - Non-matching transceiver: link shows loopback
// - Such ports show received serial polarity
// - Activity stretched at least 4 ms
// - Collision stretched at least 4 ms
// - One bit time is 100 ns
module lsm_monitor #(
	parameter int STRETCH_CYC = lsm_pkg::STRETCH_CYC,
	parameter int STROBE_CYC  = lsm_pkg::STROBE_CYC
) (
	input  wire logic                   sys_clk,
	input  wire logic                   reset_n,
	input  wire lsm_pkg::lsm_port_stat_t port_stat,
	input  wire lsm_pkg::lsm_aux_stat_t  aux_stat,
	input  wire logic                   std_non_matching,
	input  wire logic                   rev_non_matching,
	input  wire logic [1:0]             loopback_ok,
	input  wire logic [1:0]             rx_pol_serial,
	output logic [7:0]                  lamp_bus,
	output logic                        bank_select,
	output lsm_pkg::lsm_strobes_t        strobes
);
	localparam int SW = $clog2(STROBE_CYC + 1);
	localparam logic [SW-1:0] STROBE_LAST = SW'(STROBE_CYC - 1);
	localparam logic [3:0] SLOT_LAST = 4'(lsm_pkg::N_SLOTS - 1);
	localparam int NP = lsm_pkg::N_PORTS;

	logic [SW-1:0]   tick_q;
	logic [3:0]      slot_q;
	logic [NP-1:0]   act_held;
	logic [NP-1:0]   col_held;
	logic            exp_act_held;
	logic            exp_col_held;
	logic [NP-1:0]   link_eff;
	logic [NP-1:0]   pol_eff;
	logic [7:0]      lamp_d;
	lsm_pkg::lsm_attr_t attr;
	logic            bank;

	// Stretchers for every port and the expansion bus
	genvar g;
	generate
		for (g = 0; g < NP; g++)
		begin : g_str
			lsm_stretch #(.HOLD_CYC(STRETCH_CYC)) u_act (
				.sys_clk  (sys_clk),
				.reset_n  (reset_n),
				.event_in (port_stat.activity[g]),
				.held_q   (act_held[g])
			);
			lsm_stretch #(.HOLD_CYC(STRETCH_CYC)) u_col (
				.sys_clk  (sys_clk),
				.reset_n  (reset_n),
				.event_in (port_stat.collision[g]),
				.held_q   (col_held[g])
			);
		end
	endgenerate

	lsm_stretch #(.HOLD_CYC(STRETCH_CYC)) u_exp_act (
		.sys_clk  (sys_clk),
		.reset_n  (reset_n),
		.event_in (aux_stat.exp_activity),
		.held_q   (exp_act_held)
	);
	lsm_stretch #(.HOLD_CYC(STRETCH_CYC)) u_exp_col (
		.sys_clk  (sys_clk),
		.reset_n  (reset_n),
		.event_in (aux_stat.exp_collision),
		.held_q   (exp_col_held)
	);

	// Strobe timer: 64 bit times of 100 ns per slot
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			tick_q <= '0;
		else if (tick_q == STROBE_LAST)
			tick_q <= '0;
		else
			tick_q <= tick_q + 1'b1;
	end

	// Slot walks five attributes low bank, then five high bank
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			slot_q <= 4'h0;
		else if (tick_q == STROBE_LAST)
			slot_q <= (slot_q == SLOT_LAST) ? 4'h0 : slot_q + 4'h1;
	end

	// Slot decode: bank is upper half, attribute is slot modulo five
	always_comb
	begin
		bank = (slot_q >= 4'(lsm_pkg::N_ATTR));
		attr = lsm_pkg::lsm_attr_t'(bank ? 3'(slot_q - 4'(lsm_pkg::N_ATTR)) : slot_q[2:0]);
	end

	// Attachment ports on a foreign transceiver report loopback and raw polarity
	always_comb
	begin
		link_eff = port_stat.link_good;
		pol_eff  = port_stat.pol_ok;
		if (std_non_matching)
		begin
			link_eff[lsm_pkg::STD_PORT_IDX] = loopback_ok[0];
			pol_eff[lsm_pkg::STD_PORT_IDX]  = rx_pol_serial[0];
		end
		if (rev_non_matching)
		begin
			link_eff[lsm_pkg::REV_PORT_IDX] = loopback_ok[1];
			pol_eff[lsm_pkg::REV_PORT_IDX]  = rx_pol_serial[1];
		end
	end

	// Lamp bus selection; high level means good/active throughout
	always_comb
	begin
		logic [NP-1:0] v;
		v = '0;
		lamp_d = 8'h00;
		case (attr)
			lsm_pkg::LSM_ATTR_ACT:  v = act_held;
			lsm_pkg::LSM_ATTR_COL:  v = col_held;
			lsm_pkg::LSM_ATTR_PARTITION_STROBE: v = port_stat.connected;
			lsm_pkg::LSM_ATTR_LINK: v = link_eff;
			lsm_pkg::LSM_ATTR_POL:  v = pol_eff;
			default:                v = '0;
		endcase
		if (!bank)
			lamp_d = v[lsm_pkg::LO_BANK_BASE +: 8];
		else
		begin
			lamp_d[3:0] = v[lsm_pkg::HI_BANK_BASE +: 4];
			lamp_d[lsm_pkg::HI_STD_BIT] = v[lsm_pkg::STD_PORT_IDX];
			lamp_d[lsm_pkg::HI_REV_BIT] = v[lsm_pkg::REV_PORT_IDX];
			case (attr)
				lsm_pkg::LSM_ATTR_ACT: lamp_d[lsm_pkg::HI_EXP_BIT] = exp_act_held;
				lsm_pkg::LSM_ATTR_COL: lamp_d[lsm_pkg::HI_EXP_BIT] = exp_col_held;
				lsm_pkg::LSM_ATTR_LINK:
				begin
					// Only the owner of the shared serial line knows these ports
					lamp_d[lsm_pkg::HI_SHR_LO_BIT] = aux_stat.owner & aux_stat.link_good[0];
					lamp_d[lsm_pkg::HI_SHR_HI_BIT] = aux_stat.owner & aux_stat.link_good[1];
				end
				lsm_pkg::LSM_ATTR_PARTITION_STROBE:
				begin
					lamp_d[lsm_pkg::HI_SHR_LO_BIT] = aux_stat.owner & aux_stat.pol_ok[0];
					lamp_d[lsm_pkg::HI_SHR_HI_BIT] = aux_stat.owner & aux_stat.pol_ok[1];
				end
				default: lamp_d[7:6] = 2'h0;
			endcase
		end
	end

	// Registered outputs; one strobe at a time, bus aligned with it
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			lamp_bus    <= 8'h00;
			bank_select <= 1'b0;
			strobes     <= '0;
		end
		else
		begin
			lamp_bus    <= lamp_d;
			bank_select <= bank;
			strobes.activity_strobe  <= (attr == lsm_pkg::LSM_ATTR_ACT);
			strobes.collision_strobe <= (attr == lsm_pkg::LSM_ATTR_COL);
			strobes.partition_strobe <= (attr == lsm_pkg::LSM_ATTR_PARTITION_STROBE);
			strobes.link_strobe      <= (attr == lsm_pkg::LSM_ATTR_LINK);
			strobes.polarity_strobe  <= (attr == lsm_pkg::LSM_ATTR_POL);
		end
	end

	// Checks
	logic started_q;
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			started_q <= 1'b0;
		else
			started_q <= 1'b1;
	end

	chk_strobe_onehot: assert property (@(posedge sys_clk) disable iff (!reset_n)
		started_q |-> $onehot(strobes))
		else $error("strobes not one-hot");

	chk_slot_period: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(tick_q == STROBE_LAST) |=> (tick_q == '0) && $changed(slot_q))
		else $error("slot did not advance at strobe end");

	chk_slot_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(tick_q != STROBE_LAST) |=> $stable(slot_q))
		else $error("slot changed mid strobe");

	chk_bank_low: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(!bank && attr == lsm_pkg::LSM_ATTR_PARTITION_STROBE) |=> lamp_bus == $past(port_stat.connected[7:0]))
		else $error("low bank partition mismatch");

	chk_bank_high: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(bank && attr == lsm_pkg::LSM_ATTR_PARTITION_STROBE) |=> lamp_bus[3:0] == $past(port_stat.connected[11:8]))
		else $error("high bank partition mismatch");

	chk_shared_owner: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(bank && !aux_stat.owner && attr == lsm_pkg::LSM_ATTR_LINK) |=> lamp_bus[7:6] == 2'h0)
		else $error("shared link shown without ownership");

	chk_exp_act: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(bank && attr == lsm_pkg::LSM_ATTR_ACT) |=> lamp_bus[6] == $past(exp_act_held))
		else $error("expansion activity not on bit 6");

	chk_loopback: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(bank && std_non_matching && attr == lsm_pkg::LSM_ATTR_LINK) |=> lamp_bus[4] == $past(loopback_ok[0]))
		else $error("loopback status not shown");

endmodule

// ==== lsm_lamp_model.sv ====
`timescale 1ns/100ps
// Lamp rows behind the drivers: a row takes the bus only under its own lone strobe
module lsm_lamp_model (
	input  wire logic                  sys_clk,
	input  wire logic [7:0]            lamp_bus,
	input  wire logic                  bank_select,
	input  wire lsm_pkg::lsm_strobes_t strobes,
	output logic [7:0]                 lamps [10]
);
	// Two strobes at once would light two rows; such a bus is left unlatched
	always_ff @(posedge sys_clk)
	begin
		for (int a = 0; a < 5; a++)
			if (strobes == lsm_pkg::lsm_strobes_t'(5'h10 >> a))
				lamps[a + (bank_select ? 5 : 0)] <= lamp_bus;
	end
endmodule

// ==== test_lsm_monitor.sv ====
`timescale 1ns/100ps
// Bench for the lamp monitor: short strobe and hold counts keep the run brief
module test_lsm_monitor;
	localparam int SC = 8;
	localparam int HC = 200;
	logic                    sys_clk;
	logic                    reset_n;
	lsm_pkg::lsm_port_stat_t port_stat;
	lsm_pkg::lsm_aux_stat_t  aux_stat;
	logic                    std_non_matching;
	logic                    rev_non_matching;
	logic [1:0]              loopback_ok;
	logic [1:0]              rx_pol_serial;
	logic [7:0]              lamp_bus;
	logic                    bank_select;
	lsm_pkg::lsm_strobes_t   strobes;
	logic [7:0]              lamps [10];
	int                      mismatches;
	int                      samples_checked;

	lsm_monitor #(.STRETCH_CYC(HC), .STROBE_CYC(SC)) i_lsm_monitor (
		.sys_clk(sys_clk), .reset_n(reset_n), .port_stat(port_stat), .aux_stat(aux_stat),
		.std_non_matching(std_non_matching), .rev_non_matching(rev_non_matching),
		.loopback_ok(loopback_ok), .rx_pol_serial(rx_pol_serial),
		.lamp_bus(lamp_bus), .bank_select(bank_select), .strobes(strobes));
	lsm_lamp_model i_lsm_lamp_model (.sys_clk(sys_clk), .lamp_bus(lamp_bus),
		.bank_select(bank_select), .strobes(strobes), .lamps(lamps));

	// Clock
	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	function automatic logic [5:0] tgt(input int s);
		return {s >= 5, 5'h10 >> (s % 5)};
	endfunction

	task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Waits for the entry into a slot, so a whole slot remains for the row
	task automatic wait_slot(input int s);
		int n;
		for (n = 0; {bank_select, strobes} === tgt(s) && n < 200; n++) @(negedge sys_clk);
		for (; {bank_select, strobes} !== tgt(s) && n < 200; n++) @(negedge sys_clk);
		cmp("slot reached", 8'h01, 8'(n < 200));
	endtask

	task automatic row(input int s, input logic [7:0] m, input logic [7:0] exp);
		wait_slot(s);
		repeat (3) @(negedge sys_clk);
		cmp($sformatf("row %0d", s), exp, lamps[s] & m);
	endtask

	task automatic t_order();
		int n;
		// 64 bit times of 100 ns at a 40 ns clock give 160 cycles per strobe
		cmp("default strobe cycles", 8'hA0, 8'(lsm_pkg::STROBE_CYC));
		wait_slot(0);
		for (int k = 1; k <= 10; k++)
		begin
			for (n = 0; {bank_select, strobes} === tgt(k - 1) && n < 100; n++) @(negedge sys_clk);
			cmp("strobe length", 8'(SC), 8'(n));
			cmp("next slot", 8'(tgt(k % 10)), 8'({bank_select, strobes}));
		end
		$display("t_order done");
	endtask

	task automatic t_static();
		logic [1:0] sl;
		logic [1:0] sp;
		port_stat.connected = 14'h2A5C;
		port_stat.link_good = 14'h15A3;
		port_stat.pol_ok = 14'h3C69;
		aux_stat.link_good = 2'h2;
		aux_stat.pol_ok = 2'h1;
		for (int o = 1; o >= 0; o--)
		begin
			aux_stat.owner = 1'(o);
			sl = o ? aux_stat.link_good : 2'h0;
			sp = o ? aux_stat.pol_ok : 2'h0;
			row(2, 8'hFF, port_stat.connected[7:0]);
			row(3, 8'hFF, port_stat.link_good[7:0]);
			row(4, 8'hFF, port_stat.pol_ok[7:0]);
			row(7, 8'hFF, {sp, port_stat.connected[13:8]});
			row(8, 8'hFF, {sl, port_stat.link_good[13:8]});
			row(9, 8'hFF, {2'h0, port_stat.pol_ok[13:8]});
		end
		$display("t_static done");
	endtask

	task automatic t_nonmatch();
		std_non_matching = 1'b1;
		rev_non_matching = 1'b1;
		// Both bits differ from the transceiver link status, so a missed swap shows
		loopback_ok = 2'h2;
		rx_pol_serial = 2'h2;
		row(8, 8'h3F, {2'h0, loopback_ok, port_stat.link_good[11:8]});
		row(9, 8'h3F, {2'h0, rx_pol_serial, port_stat.pol_ok[11:8]});
		std_non_matching = 1'b0;
		rev_non_matching = 1'b0;
		$display("t_nonmatch done");
	endtask

	task automatic pulse();
		@(negedge sys_clk);
		port_stat.activity = 14'h0008;
		port_stat.collision = 14'h0200;
		@(negedge sys_clk);
		port_stat = '0;
	endtask

	task automatic t_stretch();
		port_stat = '0;
		aux_stat = '0;
		aux_stat.exp_activity = 1'b1;
		aux_stat.exp_collision = 1'b1;
		pulse();
		row(0, 8'hFF, 8'h08);
		row(6, 8'h7F, 8'h42);
		row(5, 8'h7F, 8'h40);
		aux_stat = '0;
		repeat (HC + 10) @(negedge sys_clk);
		pulse();
		repeat (150) @(negedge sys_clk);
		pulse();
		repeat (100) @(negedge sys_clk);
		row(0, 8'hFF, 8'h08);
		repeat (HC + 10) @(negedge sys_clk);
		row(0, 8'hFF, 8'h00);
		row(6, 8'h7F, 8'h00);
		$display("t_stretch done");
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Watchdog well beyond the roughly 1,300 cycles the tests need
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		summarize();
	end

	// Main sequence
	initial
	begin
		mismatches = 0;
		samples_checked = 0;
		reset_n = 1'b0;
		port_stat = '0;
		aux_stat = '0;
		std_non_matching = 1'b0;
		rev_non_matching = 1'b0;
		loopback_ok = 2'h3;
		rx_pol_serial = 2'h0;
		repeat (10) @(negedge sys_clk);
		reset_n = 1'b1;
		t_order();
		t_static();
		t_nonmatch();
		t_stretch();
		summarize();
	end
endmodule
